//--- core/urtc_rx_shifter.sv
// receiver: delimiter detection, mid-bit sampling, error flags
`timescale 1ns/1ps
module urtc_rx_shifter
  import urtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic rxd,
  input wire urtc_mode_t mode,
  input wire logic [15:0] baudDiv,
  output logic bitTick,
  output urtc_rx_evt_t evt
);
  urtc_rx_state_t state_r, stateNxt; // sequencer
  logic [15:0] smpCnt_r, smpCntNxt; // clocks to next sample point
  logic [15:0] tickCnt_r, tickCntNxt; // free bit-period divider
  logic [2:0] bitIdx_r, bitIdxNxt; // data bit index
  logic [7:0] shift_r, shiftNxt; // data shifter
  logic par_r, parNxt, parErr_r, parErrNxt; // running parity, parity fault
  logic tick_r, tickNxt;
  urtc_rx_evt_t evt_r, evtNxt;
  logic smpDone;

  assign smpDone = (smpCnt_r == 16'h0000);
  assign bitTick = tick_r;
  assign evt = evt_r;

  // next state of sequencer and divider
  always_comb begin
    stateNxt = state_r;
    smpCntNxt = smpDone ? smpCnt_r : smpCnt_r - 16'h0001;
    bitIdxNxt = bitIdx_r;
    shiftNxt = shift_r;
    parNxt = par_r;
    parErrNxt = parErr_r;
    evtNxt = '0;
    evtNxt.data = evt_r.data;
    // bit-period tick runs while enabled, also on an idle line
    tickCntNxt = (tickCnt_r == 16'h0000) ? baudDiv - 16'h0001 : tickCnt_r - 16'h0001;
    tickNxt = enable && (tickCnt_r == 16'h0000) && (baudDiv != 16'h0000);
    unique case (state_r)
      RX_IDLE: begin
        if (!rxd) begin
          stateNxt = RX_START;
          smpCntNxt = baudDiv >> 1;
        end
      end
      RX_START: begin
        if (smpDone) begin
          smpCntNxt = baudDiv - 16'h0001;
          parNxt = 1'b0;
          bitIdxNxt = 3'h0;
          if (rxd) begin
            stateNxt = RX_IDLE; // glitch, not a start
          end else if (mode.single_bit_delimiter_sel) begin
            stateNxt = RX_DATA; // single low bit delimits
          end else begin
            stateNxt = RX_SYNC; // sync pattern follows
          end
        end
      end
      RX_SYNC: begin
        if (smpDone) begin
          smpCntNxt = baudDiv - 16'h0001;
          if (rxd) begin
            stateNxt = RX_DATA; // low then high is a data sync
          end else begin
            stateNxt = RX_IDLE;
            evtNxt.syncErr = 1'b1;
          end
        end
      end
      RX_DATA: begin
        if (smpDone) begin
          smpCntNxt = baudDiv - 16'h0001;
          shiftNxt = {rxd, shift_r[7:1]};
          parNxt = par_r ^ rxd;
          bitIdxNxt = bitIdx_r + 3'h1;
          if (bitIdx_r == 3'h7) begin
            stateNxt = mode.parityEn ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY: begin
        if (smpDone) begin
          smpCntNxt = baudDiv - 16'h0001;
          parErrNxt = par_r ^ rxd; // even parity
          stateNxt = RX_STOP;
        end
      end
      RX_STOP: begin
        if (smpDone) begin
          // stop bit judged at its middle, not at frame end
          evtNxt.charDone = 1'b1;
          evtNxt.data = shift_r;
          evtNxt.parityErr = parErr_r & mode.parityEn;
          evtNxt.frameErr = !rxd;
          evtNxt.brk = !rxd && (shift_r == 8'h00);
          parErrNxt = 1'b0;
          stateNxt = RX_IDLE;
        end
      end
    endcase
    // disabled or reset: drop any character in progress
    if (!enable) begin
      stateNxt = RX_IDLE;
      tickCntNxt = baudDiv;
      evtNxt = '0;
      evtNxt.data = evt_r.data;
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= RX_IDLE;
      smpCnt_r <= 16'h0000;
      tickCnt_r <= 16'h0000;
      bitIdx_r <= 3'h0;
      shift_r <= 8'h00;
      par_r <= 1'b0;
      parErr_r <= 1'b0;
      tick_r <= 1'b0;
      evt_r <= '0;
    end else begin
      state_r <= stateNxt;
      smpCnt_r <= smpCntNxt;
      tickCnt_r <= tickCntNxt;
      bitIdx_r <= bitIdxNxt;
      shift_r <= shiftNxt;
      par_r <= parNxt;
      parErr_r <= parErrNxt;
      tick_r <= tickNxt;
      evt_r <= evtNxt;
    end
  end

  // stop-bit verdict follows its mid sample by one edge
  AST_FRAME_AT_MID: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == RX_STOP && smpDone && enable) |=> evt_r.charDone && (evt_r.frameErr == !$past(rxd)))
    else $error("framing verdict not taken at stop middle");
endmodule : urtc_rx_shifter

//--- core/urtc_timeout.sv
// receiver time-out counter in bit periods
`timescale 1ns/1ps
module urtc_timeout
  import urtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bitTick,
  input wire logic charDone,
  input wire logic startOnChar,
  input wire logic rearm,
  input wire logic [TO_W-1:0] toValue,
  output logic timeoutEvt,
  output logic waiting
);
  logic [TO_W-1:0] cnt_r, cntNxt; // remaining bit periods
  logic run_r, runNxt, wait_r, waitNxt, evt_r, evtNxt;

  assign timeoutEvt = evt_r;
  assign waiting = wait_r;

  // next counter state, commands first
  always_comb begin
    cntNxt = cnt_r;
    runNxt = run_r;
    waitNxt = wait_r;
    evtNxt = 1'b0;
    if (startOnChar) begin
      waitNxt = 1'b1; // clock held until a character
      runNxt = 1'b0;
      cntNxt = toValue;
    end else if (rearm) begin
      waitNxt = 1'b0; // count from the value at once
      runNxt = (toValue != '0);
      cntNxt = toValue;
    end else if (charDone && (wait_r || run_r)) begin
      waitNxt = 1'b0; // character starts or restarts the count
      runNxt = (toValue != '0);
      cntNxt = toValue;
    end else if (run_r && bitTick) begin
      if (cnt_r <= 1) begin
        evtNxt = 1'b1; // expired
        runNxt = 1'b0;
        cntNxt = '0;
      end else begin
        cntNxt = cnt_r - 1'b1;
      end
    end
  end

  // counter registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      wait_r <= 1'b0;
      evt_r <= 1'b0;
    end else begin
      cnt_r <= cntNxt;
      run_r <= runNxt;
      wait_r <= waitNxt;
      evt_r <= evtNxt;
    end
  end

  sequence sqExpire;
    evt_r ##1 !evt_r;
  endsequence
  AST_WAIT_FROZEN: assert property (@(posedge clk) disable iff (!rst_n)
    (wait_r && !charDone && !rearm && !startOnChar) |=> wait_r && $stable(cnt_r) && !evt_r)
    else $error("counter moved before first character");
  AST_REARM_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (rearm && !startOnChar && toValue > 1) |=> run_r && !wait_r && cnt_r == $past(toValue))
    else $error("rearm did not start count");
  AST_EXPIRE: assert property (@(posedge clk) disable iff (!rst_n)
    (run_r && bitTick && cnt_r == 1 && !rearm && !startOnChar && !charDone) |=> sqExpire)
    else $error("time-out event missing at zero");
endmodule : urtc_timeout

//--- core/urtc_top.sv
// top: wishbone registers, command decode, status and interrupt of the receiver control block
`timescale 1ns/1ps
// Function
// - start-on-char holds counter until first character
// - rearm counts down from value at once
// - stop bit sampled low flags framing error
// - framing flag set at stop-bit middle
// - status clear wipes five error flags
// - receiver on only when off bit clear
// - transmitter on only when off bit clear
// - sixteen-bit counter reaches 109 s at 600
// - delimiter select: one bit or sync pattern
// - spi mode uses its own command layout
module urtc_top
  import urtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic rxd,
  output logic irq,
  output logic txEnable,
  output logic txReset,
  output logic spiCsForce
);
  // bus handshake state
  logic ack_r, ackNxt; // one-cycle answer
  logic [31:0] datOut_r, datOutNxt; // read data, held through ack
  logic [7:0] reported_r, reportedNxt; // bits a read will clear

  // software registers
  urtc_mode_t mode_r, modeNxt; // spi, delimiter, parity
  logic [15:0] baud_r, baudNxt; // clocks per bit
  logic [TO_W-1:0] tov_r, tovNxt; // time-out in bit periods
  logic [7:0] mask_r, maskNxt; // interrupt mask
  logic [7:0] stat_r, statNxt; // sticky events

  // control levels and pulses
  logic receiver_on_cmd_r, rxEnNxt; // receiver enabled
  logic transmitter_on_cmd_r, txEnNxt; // transmitter enabled
  logic cs_r, csNxt; // spi chip select forced
  logic rxRst_r, rxRstNxt; // receiver reset pulse
  logic txRst_r, txRstNxt; // transmitter reset pulse
  logic irq_r, irqNxt; // interrupt level

  // decoded access
  logic req; // request present
  logic wrAct; // write takes effect at this edge
  logic rdAct; // read completes at this edge
  logic [31:0] wMask; // byte-lane mask
  logic [31:0] wData; // masked write data
  logic [31:0] cmd; // command bits of this write
  logic [7:0] evtSet; // events this cycle
  logic [7:0] clrMask; // flags cleared this cycle

  // links to the two halves
  urtc_rx_evt_t rxEvt; // received character
  logic bitTick; // one bit period elapsed
  logic toEvt; // time-out expired
  logic toWaiting; // waiting for first character
  logic startTo; // start-on-char command
  logic rearmTo; // rearm command

  // byte-lane mask from the select lines
  genvar g;
  for (g = 0; g < 4; g++) begin : gLane
    assign wMask[g*8 +: 8] = {8{wb_sel_i[g]}};
  end

  // access decode
  assign req = wb_cyc_i & wb_stb_i;
  assign wrAct = req & ack_r & wb_we_i;
  assign rdAct = req & ack_r & ~wb_we_i;
  assign wData = wb_dat_i & wMask;
  assign cmd = (wrAct && wb_adr_i == ADDR_CMD) ? wData : 32'h0000_0000;

  // time-out commands exist only in the asynchronous layout
  assign startTo = cmd[CMD_START_TO] & ~mode_r.spiMode;
  assign rearmTo = cmd[CMD_REARM_TO] & ~mode_r.spiMode;

  // outputs straight from flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = datOut_r;
  assign irq = irq_r;
  assign txEnable = transmitter_on_cmd_r;
  assign txReset = txRst_r;
  assign spiCsForce = cs_r;

  // receiver half
  urtc_rx_shifter uRx (
    .clk(clk),
    .rst_n(rst_n),
    .enable(receiver_on_cmd_r & ~rxRst_r),
    .rxd(rxd),
    .mode(mode_r),
    .baudDiv(baud_r),
    .bitTick(bitTick),
    .evt(rxEvt)
  );

  // time-out counter
  urtc_timeout uTo (
    .clk(clk),
    .rst_n(rst_n),
    .bitTick(bitTick),
    .charDone(rxEvt.charDone),
    .startOnChar(startTo),
    .rearm(rearmTo),
    .toValue(tov_r),
    .timeoutEvt(toEvt),
    .waiting(toWaiting)
  );

  // bus answer and read data
  always_comb begin
    ackNxt = req & ~ack_r;
    datOutNxt = datOut_r;
    reportedNxt = reported_r;
    // capture read data in the cycle before ack
    if (req && !ack_r && !wb_we_i) begin
      reportedNxt = 8'h00;
      unique case (wb_adr_i)
        ADDR_MODE: datOutNxt = {29'h0000_0000, mode_r};
        ADDR_BAUD: datOutNxt = {16'h0000, baud_r};
        ADDR_TOV: datOutNxt = {16'h0000, tov_r};
        ADDR_STAT: begin
          datOutNxt = {13'h0000, toWaiting, transmitter_on_cmd_r, receiver_on_cmd_r, 8'h00, stat_r};
          reportedNxt = stat_r; // only shown bits are cleared
        end
        ADDR_MASK: datOutNxt = {24'h00_0000, mask_r};
        ADDR_RXD: begin
          datOutNxt = {24'h00_0000, rxEvt.data};
          reportedNxt = 8'h01; // reading data frees the holding flag
        end
        default: datOutNxt = 32'h0000_0000; // command and unmapped read zero
      endcase
    end
  end

  // writable registers, per byte lane
  always_comb begin
    modeNxt = mode_r;
    baudNxt = baud_r;
    tovNxt = tov_r;
    maskNxt = mask_r;
    if (wrAct) begin
      unique case (wb_adr_i)
        ADDR_MODE: modeNxt = (mode_r & ~wMask[2:0]) | wData[2:0];
        ADDR_BAUD: baudNxt = (baud_r & ~wMask[15:0]) | wData[15:0];
        ADDR_TOV: tovNxt = (tov_r & ~wMask[TO_W-1:0]) | wData[TO_W-1:0];
        ADDR_MASK: maskNxt = (mask_r & ~wMask[7:0]) | wData[7:0];
        default: ; // command is decoded apart, others read-only
      endcase
    end
  end

  // command register effects
  always_comb begin
    // disable wins over enable in one write
    if (cmd[CMD_RX_OFF]) begin
      rxEnNxt = 1'b0;
    end else if (cmd[CMD_RX_ON]) begin
      rxEnNxt = 1'b1;
    end else begin
      rxEnNxt = receiver_on_cmd_r;
    end
    if (cmd[CMD_TX_OFF]) begin
      txEnNxt = 1'b0;
    end else if (cmd[CMD_TX_ON]) begin
      txEnNxt = 1'b1;
    end else begin
      txEnNxt = transmitter_on_cmd_r;
    end
    // each reset returns only its own half to idle
    rxRstNxt = cmd[CMD_RX_RST];
    txRstNxt = cmd[CMD_TX_RST];
    // chip-select bits mean something only in spi layout
    if (!mode_r.spiMode) begin
      csNxt = 1'b0;
    end else if (cmd[CMD_CS_REL]) begin
      csNxt = 1'b0;
    end else if (cmd[CMD_CS_FORCE]) begin
      csNxt = 1'b1;
    end else begin
      csNxt = cs_r;
    end
  end

  // sticky status, a new event beats any clear
  always_comb begin
    evtSet = 8'h00;
    evtSet[ST_RXRDY] = rxEvt.charDone;
    evtSet[ST_TIMEOUT] = toEvt;
    evtSet[ST_BRK] = rxEvt.brk;
    evtSet[ST_MANCHESTER_ERROR_FLAG] = rxEvt.syncErr;
    evtSet[ST_OVERRUN_ERROR_FLAG] = rxEvt.charDone & stat_r[ST_RXRDY];
    evtSet[ST_FRAME] = rxEvt.frameErr;
    evtSet[ST_PARITY_ERROR_FLAG] = rxEvt.parityErr;
    clrMask = rdAct ? reported_r : 8'h00;
    // five error flags cleared together
    if (cmd[CMD_CLR_STAT]) begin
      clrMask = clrMask | ERR_CLR_MASK;
    end
    statNxt = (stat_r & ~clrMask) | evtSet;
    irqNxt = |(statNxt & maskNxt);
  end

  // all registers of the top
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      datOut_r <= 32'h0000_0000;
      reported_r <= 8'h00;
      mode_r <= MODE_RST;
      baud_r <= BAUD_RST;
      tov_r <= TOV_RST;
      mask_r <= MASK_RST;
      stat_r <= 8'h00;
      receiver_on_cmd_r <= 1'b0;
      transmitter_on_cmd_r <= 1'b0;
      cs_r <= 1'b0;
      rxRst_r <= 1'b0;
      txRst_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ack_r <= ackNxt;
      datOut_r <= datOutNxt;
      reported_r <= reportedNxt;
      mode_r <= modeNxt;
      baud_r <= baudNxt;
      tov_r <= tovNxt;
      mask_r <= maskNxt;
      stat_r <= statNxt;
      receiver_on_cmd_r <= rxEnNxt;
      transmitter_on_cmd_r <= txEnNxt;
      cs_r <= csNxt;
      rxRst_r <= rxRstNxt;
      txRst_r <= txRstNxt;
      irq_r <= irqNxt;
    end
  end

  // checks on the top
  default clocking cbAst @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence sqReq;
    req && !ack_r;
  endsequence
  sequence sqAnswer;
    ack_r ##1 !ack_r;
  endsequence

  AST_ACK_ONCE: assert property (sqReq |=> sqAnswer)
    else $error("bus answer not a single cycle");
  AST_RX_BOTH: assert property (cmd[CMD_RX_ON] && cmd[CMD_RX_OFF] |=> !receiver_on_cmd_r)
    else $error("receiver enabled with disable set");
  AST_RX_ON: assert property (cmd[CMD_RX_ON] && !cmd[CMD_RX_OFF] |=> receiver_on_cmd_r)
    else $error("receiver not enabled");
  AST_TX_BOTH: assert property (cmd[CMD_TX_ON] && cmd[CMD_TX_OFF] |=> !txEnable)
    else $error("transmitter enabled with disable set");
  AST_TX_ON: assert property (cmd[CMD_TX_ON] && !cmd[CMD_TX_OFF] |=> txEnable)
    else $error("transmitter not enabled");
  AST_CLR_ERR: assert property ((cmd[CMD_CLR_STAT] && (evtSet & ERR_CLR_MASK) == 8'h00)
    |=> (stat_r & ERR_CLR_MASK) == 8'h00)
    else $error("error flags survived status clear");
  AST_FRAME_FLAG: assert property (rxEvt.frameErr |=> stat_r[ST_FRAME])
    else $error("framing flag not set");
  AST_SPI_IGNORE: assert property ((mode_r.spiMode && cmd[CMD_START_TO] && !toWaiting)
    |=> !toWaiting)
    else $error("time-out command acted in spi layout");
  AST_IRQ_LEVEL: assert property (##1 (irq == |(stat_r & mask_r)))
    else $error("interrupt level disagrees with status");
endmodule : urtc_top

//--- pkg/urtc_pkg.sv
// package: addresses, command bits, status layout and carriers of the receiver control block
package urtc_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_CMD = 32'h4002_4000;
  localparam logic [31:0] ADDR_MODE = 32'h4002_4004;
  localparam logic [31:0] ADDR_BAUD = 32'h4002_4008;
  localparam logic [31:0] ADDR_TOV = 32'h4002_400C;
  localparam logic [31:0] ADDR_STAT = 32'h4002_4010;
  localparam logic [31:0] ADDR_MASK = 32'h4002_4014;
  localparam logic [31:0] ADDR_RXD = 32'h4002_4018;
  // command register bit positions, asynchronous layout
  localparam int CMD_RX_RST = 2;
  localparam int CMD_TX_RST = 3;
  localparam int CMD_RX_ON = 4;
  localparam int CMD_RX_OFF = 5;
  localparam int CMD_TX_ON = 6;
  localparam int CMD_TX_OFF = 7;
  localparam int CMD_CLR_STAT = 8;
  localparam int CMD_START_TO = 11;
  localparam int CMD_REARM_TO = 15;
  // command register bit positions used only in spi layout
  localparam int CMD_CS_FORCE = 18;
  localparam int CMD_CS_REL = 19;
  // status event bit positions
  localparam int ST_RXRDY = 0;
  localparam int ST_TIMEOUT = 1;
  localparam int ST_BRK = 2;
  localparam int ST_MANCHESTER_ERROR_FLAG = 3;
  localparam int ST_OVERRUN_ERROR_FLAG = 5;
  localparam int ST_FRAME = 6;
  localparam int ST_PARITY_ERROR_FLAG = 7;
  // flags wiped by the status clear command
  localparam logic [7:0] ERR_CLR_MASK = 8'hEC;
  // time-out counter width and reset values
  localparam int TO_W = 16;
  localparam logic [15:0] BAUD_RST = 16'h00AD;
  localparam logic [15:0] TOV_RST = 16'h0000;
  localparam logic [7:0] MASK_RST = 8'h00;
  // mode register layout, bit 0 is spiMode
  typedef struct packed {
    logic parityEn;
    logic single_bit_delimiter_sel;
    logic spiMode;
  } urtc_mode_t;
  localparam urtc_mode_t MODE_RST = 3'h2;
  // one received character and its errors
  typedef struct packed {
    logic charDone;
    logic [7:0] data;
    logic parityErr;
    logic frameErr;
    logic syncErr;
    logic brk;
  } urtc_rx_evt_t;
  // receiver sequencer states
  typedef enum {RX_IDLE, RX_START, RX_SYNC, RX_DATA, RX_PARITY, RX_STOP} urtc_rx_state_t;
endpackage : urtc_pkg

//--- test/tb_usart_rx_timeout_control.sv
// testbench: register bus, serial frames, status, interrupt and time-out of the receiver control block
`timescale 1ns/1ps
module tb_usart_rx_timeout_control
  import urtc_pkg::*;
;
  localparam int B = 20; // clocks per bit
  logic clk, rst_n, wbWe, wbCyc, wbStb, rxd, irq, txEnable, txReset, spiCsForce, wbAck;
  logic [31:0] wbAdr, wbDat, wbDatO, rd, expSt;
  logic [3:0] wbSel;
  logic [7:0] d;
  int failCount = 0, testsRun = 0, cycles = 0, txRstCnt = 0, seed = 37078, rxOn = 0, txOn = 0, n;
  int seq[5] = '{1, 3, 1, 0, 2}; // on/off pairs: on, both, on, none, off
  logic [7:0] dq[$]; // characters sent
  logic [31:0] ra[7] = '{ADDR_MODE, ADDR_BAUD, ADDR_TOV, ADDR_MASK, ADDR_STAT, ADDR_CMD, 32'h4002_4020};
  logic [31:0] rv[7] = '{32'(MODE_RST), 32'(BAUD_RST), 32'(TOV_RST), 32'(MASK_RST), 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000};

  urtc_top DUT (.clk(clk), .rst_n(rst_n), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck),
    .rxd(rxd), .irq(irq), .txEnable(txEnable), .txReset(txReset), .spiCsForce(spiCsForce));
  urtc_tx_model #(.BIT_CLKS(B)) txm (.clk(clk), .rxd(rxd));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard and transmitter reset pulse counter
  always @(posedge clk) begin
    cycles++;
    if (txReset === 1'b1) txRstCnt++;
    if (cycles == 20000) begin
      failCount++;
      summarize();
    end
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle, entered just after an edge; read data lands in rd
  task automatic wb(input logic [31:0] a, input logic [31:0] dt, input logic w);
    wbAdr <= a;
    wbDat <= dt;
    wbWe <= w;
    wbSel <= 4'hF;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    // no wait-state count assumed; the hang guard ends a wait that never answers
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk);
  endtask : wb
  // status read against the model; the read clears what it shows
  task automatic readStatus(input logic [31:0] msk);
    wb(ADDR_STAT, 32'h0000_0000, 1'b0);
    check(rd & msk, (expSt | 32'(rxOn) << 16 | 32'(txOn) << 17) & msk);
    expSt = 32'h0000_0000;
  endtask : readStatus
  // last character must be the one held
  task automatic readRx();
    wb(ADDR_RXD, 32'h0000_0000, 1'b0);
    check(rd & 32'h0000_00FF, 32'(dq[$]));
    dq.delete();
    expSt[0] = 1'b0;
  endtask : readRx
  // send a frame and predict its status events
  task automatic sendM(input logic [7:0] c, input int syn, input int par, input logic stp, input logic se,
    input logic pe);
    txm.sendChar(c, syn, par, stp);
    // one idle bit after a low stop, so the line low at stop end never merges with the next start
    if (!stp) repeat (B) @(posedge clk);
    repeat (2) @(posedge clk);
    if (expSt[0]) expSt[5] = 1'b1;
    expSt[0] = 1'b1;
    expSt[6] = expSt[6] | ~stp;
    expSt[2] = expSt[2] | (c == 8'h00 && !stp);
    expSt[3] = expSt[3] | se;
    expSt[7] = expSt[7] | pe;
    dq.push_back(c);
  endtask : sendM
  // verdict and end of run
  task automatic summarize();
    if (failCount == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    rst_n = 1'b0;
    {wbWe, wbCyc, wbStb} = 3'h0;
    wbAdr = 32'h0000_0000;
    wbDat = 32'h0000_0000;
    wbSel = 4'h0;
    expSt = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({irq, txEnable, spiCsForce}, 32'h0000_0000);
    // reset values, command reads zero, unmapped reads zero
    for (int i = 0; i < 7; i++) begin
      wb(ra[i], 32'h0000_0000, 1'b0);
      check(rd, rv[i]);
    end
    d = 8'($random(seed));
    wb(ADDR_MASK, 32'(d), 1'b1);
    wb(ADDR_MASK, 32'h0000_0000, 1'b0);
    check(rd, 32'(d));
    wb(ADDR_BAUD, 32'(B), 1'b1);
    // full sixteen-bit time-out value kept
    wb(ADDR_TOV, 32'hFFFF_FFFF, 1'b1);
    wb(ADDR_TOV, 32'h0000_0000, 1'b0);
    check(rd, 32'h0000_FFFF);
    // on/off pairs for both halves, off wins
    foreach (seq[k]) begin
      wb(ADDR_CMD, 32'(seq[k]) << 4 | 32'(seq[k]) << 6, 1'b1);
      rxOn = seq[k][1] ? 0 : (seq[k][0] ? 1 : rxOn);
      txOn = seq[k][1] ? 0 : (seq[k][0] ? 1 : txOn);
      readStatus(32'h0003_0000);
      check(txEnable, 32'(txOn));
    end
    wb(ADDR_CMD, 32'h0000_0050, 1'b1);
    rxOn = 1;
    txOn = 1;
    // half resets touch only their own half
    n = txRstCnt;
    wb(ADDR_CMD, 32'h0000_0008, 1'b1);
    repeat (3) @(posedge clk);
    check(32'(txRstCnt - n), 32'h0000_0001);
    wb(ADDR_CMD, 32'h0000_0004, 1'b1);
    repeat (3) @(posedge clk);
    check(32'(txRstCnt - n), 32'h0000_0001);
    check(txEnable, 32'h0000_0001);
    readStatus(32'h0003_0000);
    // low stop bit: flag up before the stop bit ends
    wb(ADDR_MASK, 32'h0000_0040, 1'b1);
    d = 8'($random(seed)) | 8'h01;
    fork
      sendM(d, -1, -1, 1'b0, 1'b0, 1'b0);
      begin
        repeat (B * 9 + B / 2 + 8) @(posedge clk);
        check(irq, 32'h0000_0001);
      end
    join
    readRx();
    readStatus(32'h0003_00FF);
    repeat (2) @(posedge clk);
    check(irq, 32'h0000_0000);
    // parity, break, frame, overrun all cleared by one command, masked irq stays low
    wb(ADDR_MASK, 32'h0000_0000, 1'b1);
    wb(ADDR_MODE, 32'h0000_0006, 1'b1);
    sendM(8'h00, -1, 1, 1'b0, 1'b0, 1'b1);
    d = 8'($random(seed));
    sendM(d, -1, int'(^d), 1'b1, 1'b0, 1'b0);
    check(irq, 32'h0000_0000);
    wb(ADDR_CMD, 32'h0000_0100, 1'b1);
    expSt = expSt & ~32'(ERR_CLR_MASK);
    readStatus(32'h0003_00FF);
    // two-bit delimiter: bad then good sync
    wb(ADDR_MODE, 32'h0000_0000, 1'b1);
    // all-ones data leaves no low bit after the sync fault for a false restart
    sendM(8'hFF, 0, -1, 1'b1, 1'b1, 1'b0);
    readStatus(32'h0000_0008);
    d = 8'($random(seed));
    sendM(d, 1, -1, 1'b1, 1'b0, 1'b0);
    readRx();
    readStatus(32'h0003_00FF);
    // spi layout of the command word
    wb(ADDR_MODE, 32'h0000_0001, 1'b1);
    wb(ADDR_CMD, 32'h0004_0000, 1'b1);
    check(spiCsForce, 32'h0000_0001);
    // start-on-char bit means nothing in spi layout
    wb(ADDR_CMD, 32'h0000_0800, 1'b1);
    wb(ADDR_STAT, 32'h0000_0000, 1'b0);
    check(rd & 32'h0004_0000, 32'h0000_0000);
    wb(ADDR_CMD, 32'h000C_0000, 1'b1);
    check(spiCsForce, 32'h0000_0000);
    wb(ADDR_MODE, 32'h0000_0002, 1'b1);
    wb(ADDR_CMD, 32'h0004_0000, 1'b1);
    check(spiCsForce, 32'h0000_0000);
    // rearm: counts five bit periods at once
    wb(ADDR_MASK, 32'h0000_0002, 1'b1);
    wb(ADDR_TOV, 32'h0000_0005, 1'b1);
    wb(ADDR_CMD, 32'h0000_8000, 1'b1);
    n = 0;
    while (irq !== 1'b1 && n < 8 * B) begin
      @(posedge clk);
      n++;
    end
    check(32'(n >= 4 * B && n <= 6 * B + 8), 32'h0000_0001);
    wb(ADDR_TOV, 32'h0000_0000, 1'b1);
    expSt[1] = 1'b1;
    readStatus(32'h0000_0002);
    // start on character: idle line never times out
    wb(ADDR_TOV, 32'h0000_0005, 1'b1);
    wb(ADDR_CMD, 32'h0000_0800, 1'b1);
    repeat (10 * B) @(posedge clk);
    check(irq, 32'h0000_0000);
    wb(ADDR_STAT, 32'h0000_0000, 1'b0);
    check(rd & 32'h0004_0002, 32'h0004_0000);
    sendM(8'($random(seed)), -1, -1, 1'b1, 1'b0, 1'b0);
    n = 0;
    while (irq !== 1'b1 && n < 8 * B) begin
      @(posedge clk);
      n++;
    end
    check(32'(n >= 3 * B && n <= 6 * B + 8), 32'h0000_0001);
    summarize();
  end
endmodule : tb_usart_rx_timeout_control

//--- test/urtc_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module urtc_tx_model #(
  parameter int BIT_CLKS = 20
) (
  input wire logic clk,
  output logic rxd
);
  // line idles high between frames
  initial begin
    rxd = 1'b1;
  end
  // one bit cell, changed just after an edge
  task automatic putBit(input logic b);
    rxd <= b;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : putBit
  // start, optional sync bit, 8 data lsb first, optional parity, stop; a negative level leaves a bit out
  task automatic sendChar(input logic [7:0] d, input int syncLvl, input int parLvl, input logic stopLvl);
    @(posedge clk);
    putBit(1'b0);
    if (syncLvl >= 0) begin
      putBit(syncLvl[0]);
    end
    for (int i = 0; i < 8; i++) begin
      putBit(d[i]);
    end
    if (parLvl >= 0) begin
      putBit(parLvl[0]);
    end
    putBit(stopLvl);
    rxd <= 1'b1;
  endtask : sendChar
endmodule : urtc_tx_model
